// ### verilog/tdpc_timer.sv
// 16-bit timer with dual PWM output and capture/compare modes
//Contract
//- Dual PWM mode needs mode field plus extra high mode bit.
//- Written count is the start count only for first PWM pass.
//- Later PWM passes always restart at 0001H.
//- Dual PWM turns shared input pin into complementary output.
//- PWM period is reload times prescale system clocks.
//- Start count other than 0001H gives one-shot first period.
//- Capture mode idles until first input edge of chosen polarity.
//- Capture mode counts prescaled system clock, not the pin.
//- Later qualifying edges latch count into PWM value; the code latches it into capture_o instead.
//- Capture interrupts, reloads 0001H and keeps counting.
//- Capture interrupt sets input capture flag.
//- Without capture, count to compare value, interrupt, reload 0001H.
//- Compare interrupt clears input capture flag.
//- Interrupt on both events by default, or select one only.
//- Control holds initial output level and transition sense.
//- PWM control holds dead band delay for the output pair.
`timescale 1ns/1ps
`include "tdpc_params.svh"
module tdpc_timer
   import tdpc_pkg::*;
(
   input  wire logic              clk_i,         // 100 MHz system clock
   input  wire logic              rst_n_i,       // Async reset, active low
   input  wire tdpc_pkg::tdpc_cfg_t cfg_i,       // Control bits
   input  wire tdpc_pkg::tdpc_val_t val_i,       // Count/PWM/reload/dead band
   input  wire logic              timer_in_i,    // Timer input pin level
   output logic                   timer_out_o,   // Timer output pin
   output logic                   timer_comp_o,  // Complement output pin
   output logic                   comp_oe_n_o,   // Low while complement drives
   output logic [15:0]            count_o,       // Current count
   output logic [15:0]            capture_o,     // Captured count
   output logic                   input_capture_flag_o, // Last event was capture
   output logic                   irq_o          // One-cycle interrupt pulse
);
   import tdpc_pkg::*;

   tdpc_state_t state;
   logic [15:0] count;
   logic [6:0]  pre_cnt;
   logic        in_d;
   logic        pwm_raw;
   logic [7:0]  dly_main;
   logic [7:0]  dly_comp;

   function automatic logic is_dual(input tdpc_cfg_t c);
      is_dual = c.mode_high_bit && (c.mode == `TDPC_MODE_DUAL_LOW);
   endfunction : is_dual

   function automatic logic is_capcmp(input tdpc_cfg_t c);
      is_capcmp = !c.mode_high_bit && (c.mode == `TDPC_MODE_CAPCMP);
   endfunction : is_capcmp

   wire logic       dual  = is_dual(cfg_i);
   wire logic       capm  = is_capcmp(cfg_i);
   wire logic [6:0] pre_top = 7'((8'h01 << cfg_i.prescale) - 8'h01);
   wire logic       tick  = (pre_cnt == pre_top);
   // Qualifying edge: rising when polarity bit is 0, falling when 1
   wire logic       edge_q = cfg_i.timer_polarity_bit ? (in_d && !timer_in_i)
                                                      : (!in_d && timer_in_i);
   wire logic       at_reload = (count == val_i.reload);
   wire logic       cap_ev = capm && (state == TDPC_RUN) && edge_q;
   wire logic       cmp_ev = capm && (state == TDPC_RUN) && tick && at_reload && !edge_q;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         in_d <= 1'b0;
      end else begin
         in_d <= timer_in_i;
      end
   end

   // Prescaler restarts with each count period so period = reload * prescale
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pre_cnt <= 7'h00;
      end else if (state != TDPC_RUN || tick || cap_ev) begin
         pre_cnt <= 7'h00;
      end else begin
         pre_cnt <= pre_cnt + 7'h01;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= TDPC_OFF;
      end else begin
         case (state)
            TDPC_OFF: begin
               if (cfg_i.enable) begin
                  state <= capm ? TDPC_WAIT : TDPC_RUN;
               end
            end
            TDPC_WAIT: begin
               if (!cfg_i.enable) begin
                  state <= TDPC_OFF;
               end else if (edge_q) begin
                  state <= TDPC_RUN;
               end
            end
            TDPC_RUN: begin
               if (!cfg_i.enable) begin
                  state <= TDPC_OFF;
               end
            end
            default: state <= TDPC_OFF;
         endcase
      end
   end

   // Count loads the written start only while stopped; wraps go to 0001H
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count <= `TDPC_RESTART_COUNT;
      end else if (state == TDPC_OFF) begin
         count <= val_i.start_count;
      end else if (cap_ev) begin
         count <= `TDPC_RESTART_COUNT;
      end else if (state == TDPC_RUN && tick) begin
         count <= at_reload ? `TDPC_RESTART_COUNT : count + 16'h0001;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         capture_o <= 16'h0000;
      end else if (cap_ev) begin
         capture_o <= count;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         input_capture_flag_o <= 1'b0;
      end else if (cap_ev) begin
         input_capture_flag_o <= 1'b1;
      end else if (cmp_ev) begin
         input_capture_flag_o <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_o <= 1'b0;
      end else begin
         case (cfg_i.interrupt_source_select)
            `TDPC_IRQ_CAPTURE: irq_o <= cap_ev;
            `TDPC_IRQ_RELOAD:  irq_o <= cmp_ev;
            default:           irq_o <= cap_ev || cmp_ev;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count_o <= `TDPC_RESTART_COUNT;
      end else begin
         count_o <= count;
      end
   end

   // Output starts at the polarity level and toggles at PWM and reload
   always_comb begin
      if (state != TDPC_RUN || capm) begin
         pwm_raw = cfg_i.timer_polarity_bit;
      end else begin
         pwm_raw = (count > val_i.pwm_value) ^ cfg_i.timer_polarity_bit;
      end
   end

   // Dead band: a rising edge waits dead_band clocks, falling edges are immediate
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dly_main <= 8'h00;
         dly_comp <= 8'h00;
      end else begin
         dly_main <= pwm_raw ? ((dly_main == val_i.dead_band) ? dly_main
                                : dly_main + 8'h01) : 8'h00;
         dly_comp <= !pwm_raw ? ((dly_comp == val_i.dead_band) ? dly_comp
                                : dly_comp + 8'h01) : 8'h00;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         timer_out_o  <= 1'b0;
         timer_comp_o <= 1'b0;
      end else if (dual) begin
         timer_out_o  <= pwm_raw && (dly_main == val_i.dead_band);
         timer_comp_o <= !pwm_raw && (dly_comp == val_i.dead_band);
      end else begin
         timer_out_o  <= pwm_raw;
         timer_comp_o <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         comp_oe_n_o <= 1'b1;
      end else begin
         comp_oe_n_o <= !dual;
      end
   end

   never_both_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !(timer_out_o && timer_comp_o))
      else $error("both PWM outputs active");
   wait_idle_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      state == TDPC_WAIT |=> $stable(count))
      else $error("count moved before first edge");
   cap_restart_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      cap_ev |=> count == 16'h0001 && capture_o == $past(count))
      else $error("capture did not latch and restart");
   cap_flag_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      cap_ev |=> input_capture_flag_o)
      else $error("capture flag not set");
   cmp_flag_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      cmp_ev |=> !input_capture_flag_o && count == 16'h0001)
      else $error("compare did not clear flag or wrap");
   irq_src_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      irq_o |-> $past(cap_ev || cmp_ev))
      else $error("interrupt without event");
   comp_pin_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      dual |=> !comp_oe_n_o)
      else $error("complement pin not driven in dual mode");
   off_load_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      state == TDPC_OFF |=> count == $past(val_i.start_count))
      else $error("start count not loaded while stopped");
   run_step_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      state == TDPC_RUN && tick && !at_reload && !cap_ev && cfg_i.enable
      |=> count == $past(count) + 16'h0001)
      else $error("count did not step on prescale tick");

   // Output level and complement pin checks
   idle_level_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (state != TDPC_RUN || capm) && !dual |=> timer_out_o == $past(cfg_i.timer_polarity_bit))
      else $error("idle output level differs from polarity bit");

   pwm_high_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      state == TDPC_RUN && !capm && !dual && count > val_i.pwm_value
      |=> timer_out_o == !$past(cfg_i.timer_polarity_bit))
      else $error("output not toggled past PWM value");

   pwm_low_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      state == TDPC_RUN && !capm && !dual && count <= val_i.pwm_value
      |=> timer_out_o == $past(cfg_i.timer_polarity_bit))
      else $error("output left initial level too early");

   comp_quiet_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !dual |=> !timer_comp_o)
      else $error("complement active outside dual mode");

   pin_input_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !dual |=> comp_oe_n_o)
      else $error("shared pin driven outside dual mode");

   // A dead band of one or more clocks leaves a gap before each rising edge
   main_gap_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      dual && val_i.dead_band != 8'h00 && $rose(timer_out_o) |-> $past(!timer_comp_o))
      else $error("main output rose without dead band");

   comp_gap_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      dual && val_i.dead_band != 8'h00 && $rose(timer_comp_o) |-> $past(!timer_out_o))
      else $error("complement rose without dead band");

   // State sequencing
   cap_arm_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      state == TDPC_OFF && cfg_i.enable && capm |=> state == TDPC_WAIT)
      else $error("capture mode did not wait for edge");

   pwm_start_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      state == TDPC_OFF && cfg_i.enable && !capm |=> state == TDPC_RUN)
      else $error("PWM mode did not start on enable");

   edge_start_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      state == TDPC_WAIT && cfg_i.enable && edge_q |=> state == TDPC_RUN)
      else $error("qualifying edge did not start counting");

   stop_off_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      state != TDPC_OFF && !cfg_i.enable |=> state == TDPC_OFF)
      else $error("disable did not stop the timer");

   keep_run_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      state == TDPC_RUN && cfg_i.enable |=> state == TDPC_RUN)
      else $error("timer stopped while enabled");

   // Counter and prescaler
   wrap_one_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      state == TDPC_RUN && tick && at_reload && !cap_ev |=> count == `TDPC_RESTART_COUNT)
      else $error("count did not restart at reload");

   hold_count_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      state == TDPC_RUN && !tick && !cap_ev |=> $stable(count))
      else $error("count moved between prescale ticks");

   pre_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      state != TDPC_RUN |=> pre_cnt == 7'h00)
      else $error("prescaler not cleared while stopped");

   pre_step_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      state == TDPC_RUN && !tick && !cap_ev |=> pre_cnt == $past(pre_cnt) + 7'h01)
      else $error("prescaler did not advance");

   // Capture register and flag
   cap_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !cap_ev |=> $stable(capture_o))
      else $error("capture value changed without capture");

   flag_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !cap_ev && !cmp_ev |=> $stable(input_capture_flag_o))
      else $error("capture flag changed without event");

   flag_keep_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      input_capture_flag_o && !cmp_ev |=> input_capture_flag_o)
      else $error("capture flag lost before compare");

   // Interrupt routing
   cap_irq_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      cap_ev && cfg_i.interrupt_source_select != `TDPC_IRQ_RELOAD |=> irq_o)
      else $error("capture interrupt missing");

   cmp_irq_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      cmp_ev && cfg_i.interrupt_source_select != `TDPC_IRQ_CAPTURE |=> irq_o)
      else $error("compare interrupt missing");

   cap_only_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      cfg_i.interrupt_source_select == `TDPC_IRQ_CAPTURE && !cap_ev |=> !irq_o)
      else $error("interrupt in capture-only setting");

   reload_only_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      cfg_i.interrupt_source_select == `TDPC_IRQ_RELOAD && !cmp_ev |=> !irq_o)
      else $error("interrupt in reload-only setting");

   wait_quiet_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      state == TDPC_WAIT |=> !irq_o)
      else $error("interrupt before first edge");

   off_quiet_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      state == TDPC_OFF |=> !irq_o)
      else $error("interrupt while stopped");

   capture_c: cover property (@(posedge clk_i) disable iff (!rst_n_i) cap_ev);
   compare_c: cover property (@(posedge clk_i) disable iff (!rst_n_i) cmp_ev);
   dual_c:    cover property (@(posedge clk_i) disable iff (!rst_n_i)
      dual && timer_comp_o ##[1:300] timer_out_o);
   arm_c:     cover property (@(posedge clk_i) disable iff (!rst_n_i)
      state == TDPC_WAIT ##1 state == TDPC_RUN);
endmodule : tdpc_timer

// ### verilog/tdpc_params.svh
// Constants for the dual PWM / capture-compare timer
`ifndef TDPC_PARAMS_SVH
`define TDPC_PARAMS_SVH
`define TDPC_RESTART_COUNT  16'h0001
`define TDPC_PRESCALE_W     3
`define TDPC_MODE_W         3
`define TDPC_MODE_CAPCMP    3'h7
`define TDPC_MODE_PWM       3'h3
`define TDPC_MODE_DUAL_LOW  3'h0
`define TDPC_IRQ_BOTH       2'h0
`define TDPC_IRQ_CAPTURE    2'h2
`define TDPC_IRQ_RELOAD     2'h3
`endif

// ### verilog/tdpc_pkg.sv
// Types for the dual PWM / capture-compare timer
package tdpc_pkg;
   typedef struct packed {
      logic        enable;            // Timer running
      logic [2:0]  mode;              // Mode field of main control
      logic        mode_high_bit;     // Extra mode bit in second control
      logic [2:0]  prescale;          // Divide by 2**prescale
      logic        timer_polarity_bit; // Output level / capture edge
      logic [1:0]  interrupt_source_select; // Which events interrupt
   } tdpc_cfg_t;
   typedef struct packed {
      logic [15:0] start_count;       // Count written by software
      logic [15:0] pwm_value;         // PWM high/low bytes
      logic [15:0] reload;            // Reload / compare value
      logic [7:0]  dead_band;         // Dead band delay in clocks
   } tdpc_val_t;
   typedef enum logic [1:0] {TDPC_OFF, TDPC_WAIT, TDPC_RUN} tdpc_state_t;
endpackage : tdpc_pkg

// ### tb/tdpc_pin_model.sv
// Far-side circuitry on the shared timer input / complement pin
`timescale 1ns/1ps
module tdpc_pin_model (
   input  wire logic clk_i,       // System clock
   input  wire logic level_i,     // Level the far circuit applies
   input  wire logic comp_i,      // Complement output of the timer
   input  wire logic comp_oe_n_i, // Low while the timer drives the pin
   output logic      pin_o        // Resolved pin level seen by the timer
);
   // Far driver backs off once the timer owns the pin, so no contention
   always_ff @(posedge clk_i) begin
      pin_o <= comp_oe_n_i ? level_i : comp_i;
   end
endmodule : tdpc_pin_model

// ### tb/tdpc_timer_tb_top.sv
// Self-checking bench for the dual PWM / capture-compare timer
`timescale 1ns/1ps
`include "tdpc_params.svh"
module tdpc_timer_tb_top;
   import tdpc_pkg::*;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   tdpc_cfg_t   cfg = '0;
   tdpc_val_t   val = '0;
   logic        lvl = 1'b0;
   logic        pol = 1'b0;
   logic [2:0]  ps;
   logic        pin, t_out, t_comp, oe_n, flag, irq;
   logic [15:0] cnt, cap;
   int          miscompares = 0;
   int          total_checks = 0;
   int          seed = 32'h9023e487;
   int          gap, scale, rl, irqs, lows, highs, both;

   always #5 clk = ~clk;

   tdpc_timer tdpc_timer_inst (.clk_i(clk), .rst_n_i(rst_n), .cfg_i(cfg), .val_i(val),
      .timer_in_i(pin), .timer_out_o(t_out), .timer_comp_o(t_comp), .comp_oe_n_o(oe_n),
      .count_o(cnt), .capture_o(cap), .input_capture_flag_o(flag), .irq_o(irq));
   tdpc_pin_model tdpc_pin_model_inst (.clk_i(clk), .level_i(lvl), .comp_i(t_comp),
      .comp_oe_n_i(oe_n), .pin_o(pin));

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : report_and_stop

   task automatic cmp_bit(input logic got, input logic exp, input string what);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: %s", $time, what);
      end
   endtask : cmp_bit

   task automatic cmp_num(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: %s got %0d want %0d", $time, what, got, exp);
      end
   endtask : cmp_num

   // Inputs change 1 ns after the edge; pin activity is tallied per cycle
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clk);
         #1;
         irqs += (irq === 1'b1);
         lows += (t_out === 1'b0 && t_comp === 1'b0);
         highs += (t_out === 1'b1);
         both += (t_out === 1'b1 && t_comp === 1'b1);
      end
   endtask : tick

   // Cycles until the visible count steps back to the restart value
   task automatic wait_restart(output int n);
      logic [15:0] prev;
      n = 0;
      do begin
         prev = cnt;
         tick(1);
         n++;
         if (n > 4000) begin
            miscompares++;
            $display("unexpected at %0t: no restart", $time);
            report_and_stop();
         end
      end while (!(cnt === `TDPC_RESTART_COUNT && prev !== `TDPC_RESTART_COUNT));
   endtask : wait_restart

   task automatic start(input logic [2:0] md, input logic hi, input logic [1:0] sel,
                        input logic [15:0] st, input logic [15:0] pw, input logic [7:0] db);
      cfg.enable = 1'b0;
      lvl = ~pol;
      tick(2);
      cfg = '{1'b0, md, hi, ps, pol, sel};
      val = '{st, pw, 16'(rl), db};
      tick(1);
      cfg.enable = 1'b1;
      irqs = 0;
      both = 0;
      tick(3);
      lvl = pol; // Wrong-sense edge must not start counting
   endtask : start

   initial begin
      repeat (4) @(posedge clk);
      cmp_num({16'h0000, cnt}, 32'h0001, "reset count");
      cmp_bit(oe_n, 1'b1, "reset pin enable");
      #1 rst_n = 1'b1;
      tick(1);
      for (int sel = 0; sel < 4; sel++) begin
         pol = sel[0];
         ps = 3'($random(seed) & 1);
         rl = 6 + ($random(seed) & 15);
         scale = 1 << ps;
         start(`TDPC_MODE_CAPCMP, 1'b0, sel[1:0], 16'h0001, 16'h0000, 8'h00);
         tick(2 * rl * scale + 8);
         cmp_num(irqs, 0, "idle before edge");
         lvl = ~pol;
         wait_restart(gap);
         lvl = pol;
         wait_restart(gap);
         cmp_num(gap, rl * scale, "compare period");
         tick(3);
         cmp_bit(flag, 1'b0, "flag after compare");
         irqs = 0;
         repeat (2) begin
            lvl = ~pol;
            wait_restart(gap);
            lvl = pol;
            tick(3);
            cmp_bit(flag, 1'b1, "flag after capture");
            cmp_bit(cap >= 16'h0002 && cap <= 16'(rl), 1'b1, "capture value");
         end
         wait_restart(gap);
         cmp_num(gap, rl * scale - 3, "restart after capture");
         tick(3);
         cmp_num(irqs, (sel == 2) ? 2 : (sel == 3) ? 1 : 3, "irq sources");
         cmp_bit(oe_n, 1'b1, "pin stays input");
         $display("capture/compare test %0d done", sel);
      end
      pol = 1'b0;
      ps = 3'($random(seed) & 1);
      rl = 20 + ($random(seed) & 15);
      scale = 1 << ps;
      start(`TDPC_MODE_DUAL_LOW, 1'b0, `TDPC_IRQ_BOTH, 16'h0001, 16'(rl / 2), 8'h02);
      tick(20);
      cmp_bit(oe_n, 1'b1, "dual needs high bit");
      start(`TDPC_MODE_DUAL_LOW, 1'b1, `TDPC_IRQ_BOTH, 16'(rl - 3), 16'(rl / 2), 8'h02);
      wait_restart(gap);
      cmp_bit(gap >= 4 * scale - 3 && gap <= 4 * scale + 2, 1'b1, "first pass");
      wait_restart(gap);
      lows = 0;
      highs = 0;
      wait_restart(gap);
      cmp_num(gap, rl * scale, "pwm period");
      cmp_num(lows, 4, "dead band cycles");
      cmp_num(highs, (rl - rl / 2) * scale - 2, "high phase");
      cmp_num(both, 0, "outputs overlap");
      cmp_bit(oe_n, 1'b0, "complement driven");
      $display("dual pwm test done");
      report_and_stop();
   end
endmodule : tdpc_timer_tb_top
